// ==== rtl/crmp_pkg.sv ====
/*
  Shared constants for the configuration message port: control tokens, destination
  suffixes, field widths, bank layout and the processor status resource format.
  Assumes a byte-wide token stream where each byte is marked as control or data.
*/
// Operation
// - Configuration state split into ten register banks
// - Status registers read and written whole words
// - Status resource id is number<<8 OR 0x0C
// - Tile destination low 16 bits are C20C
// - Node destination low 16 bits are c30C
// - Write: 192, return id, register, data, 1
// - Read: 193, return id, register, 1
// - Write reply 3,1 success or 4,1 failure
// - Read reply 3, value, 1 or 4,1
// - Node and tile registers share message formats
package crmp_pkg;
  localparam logic [7:0]  TOK_WRITE     = 8'hc0;   // Opening token of a write
  localparam logic [7:0]  TOK_READ      = 8'hc1;   // Opening token of a read
  localparam logic [7:0]  TOK_END       = 8'h01;   // Closing token of every message
  localparam logic [7:0]  TOK_ACK       = 8'h03;   // Success reply token
  localparam logic [7:0]  TOK_NACK      = 8'h04;   // Failure reply token
  localparam logic [15:0] TILE_SUFFIX   = 16'hc20c;
  localparam logic [15:0] NODE_SUFFIX   = 16'hc30c;
  localparam logic [7:0]  PS_RES_TYPE   = 8'h0c;   // Low byte of a status resource id
  localparam int          PS_NUM_SHIFT  = 8;
  localparam int          RET_ID_BYTES  = 3;
  localparam int          REG_NUM_BYTES = 2;
  localparam int          DATA_BYTES    = 4;
  localparam int          NUM_BANKS     = 10;
  localparam int          REGS_PER_BANK = 4;
  localparam int          BANK_LSB      = 8;       // Register number bits 11:8 pick the bank
  localparam int          BANK_MSB      = 11;
  localparam int          FIFO_DEPTH    = 4;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
endpackage

// ==== rtl/crmp_link_if.sv ====
/*
  Token link between a requesting channel-end and the configuration agent.
  Assumes both ends share one clock; each byte moves when valid and ready are high.
*/
`timescale 1ns/10ps
interface crmp_link_if;
  logic        req_valid;
  logic        req_ready;
  logic        req_ctrl;    // Byte is a control token
  logic [7:0]  req_data;
  logic [31:0] req_dest;    // Channel-end destination, steady through a message
  logic        rsp_valid;
  logic        rsp_ready;
  logic        rsp_ctrl;
  logic [7:0]  rsp_data;
  logic [23:0] rsp_dest;    // Return channel-end of the reply

  modport dev (input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
               output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
  modport req (output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
               input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
endinterface // crmp_link_if

// ==== rtl/crmp_agent.sv ====
/*
  Device end: request FIFO plus the configuration agent that parses messages,
  accesses the banked registers and returns reply tokens. Also serves the
  processor's direct status-get/status-set port on bank 0.
  Assumes one clock, synchronous active-high reset, link joined by the bench.
*/
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module crmp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign o_in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and count update
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; entries are only read once written
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
endmodule // crmp_fifo

////////////////////////////////////////////////////////////////////////////////
module crmp_agent #(
  parameter int NUM_BANKS     = crmp_pkg::NUM_BANKS,
  parameter int REGS_PER_BANK = crmp_pkg::REGS_PER_BANK,
  parameter int FIFO_DEPTH    = crmp_pkg::FIFO_DEPTH
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  crmp_link_if.dev         link,
  input  wire logic        i_ps_en,      // Status-get or status-set this cycle
  input  wire logic        i_ps_write,
  input  wire logic [31:0] i_ps_resid,
  input  wire logic [31:0] i_ps_wdata,
  output logic      [31:0] o_ps_rdata,
  output logic             o_ps_bad,     // Last status access had a bad identifier
  output logic             o_busy
);
  localparam int NREG = NUM_BANKS * REGS_PER_BANK;
  localparam int AW   = $clog2(NREG);

  typedef enum {ST_IDLE, ST_RETID, ST_REGNUM, ST_WDATA, ST_ENDTOK, ST_DRAIN,
                ST_EXEC, ST_REPLY} crmp_state_e;

  crmp_state_e st_reg, st_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic [2:0]  idx_reg, idx_next;
  logic        wr_op_reg, wr_op_next, fail_reg, fail_next;
  logic [23:0] ret_reg, ret_next;
  logic [15:0] num_reg, num_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [31:0] ps_rdata_next;
  logic        ps_bad_next;
  logic [31:0] regs [NREG];
  logic        mem_we;
  logic [AW-1:0] mem_addr, msg_addr, ps_addr;
  logic [31:0] mem_wdata;
  logic        msg_ok, ps_ok, dest_ok, last;
  logic        f_valid, f_ready, f_ctrl;
  logic [7:0]  f_data;

  // Request bytes pass a small FIFO; its ready is the link's ready
  crmp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (link.req_valid),
    .o_in_ready  (link.req_ready),
    .i_in_data   ({link.req_ctrl, link.req_data}),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  ({f_ctrl, f_data})
  );

  // Bank decode: bits 11:8 choose one of the banks, low byte the word
  assign msg_ok = (num_reg[15:12] == 4'h0)
                && (32'(num_reg[crmp_pkg::BANK_MSB:crmp_pkg::BANK_LSB]) < NUM_BANKS)
                && (32'(num_reg[7:0]) < REGS_PER_BANK);
  assign msg_addr = AW'(32'(num_reg[crmp_pkg::BANK_MSB:crmp_pkg::BANK_LSB]) * REGS_PER_BANK
                        + 32'(num_reg[7:0]));
  // Status resource id carries the number above the type byte, bank 0
  assign ps_ok   = (i_ps_resid[7:0] == crmp_pkg::PS_RES_TYPE) && (i_ps_resid[31:16] == 16'h0)
                 && (32'(i_ps_resid[15:crmp_pkg::PS_NUM_SHIFT]) < REGS_PER_BANK);
  assign ps_addr = AW'(i_ps_resid[15:crmp_pkg::PS_NUM_SHIFT]);
  // Tile and node destinations are served alike
  assign dest_ok = (link.req_dest[15:0] == crmp_pkg::TILE_SUFFIX)
                 || (link.req_dest[15:0] == crmp_pkg::NODE_SUFFIX);

  // Register write port: status-set wins, a message write waits in ST_EXEC until a cycle with no status-set
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = msg_addr;
    mem_wdata = wdata_reg;
    if (i_ps_en && i_ps_write && ps_ok) begin
      mem_we    = 1'b1;
      mem_addr  = ps_addr;
      mem_wdata = i_ps_wdata;
    end else if (st_reg == ST_EXEC && !fail_reg && msg_ok && wr_op_reg) begin
      mem_we = 1'b1;   // only a valid register is written
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= crmp_pkg::REG_RESET;
      end
    end else if (mem_we) begin
      regs[mem_addr] <= mem_wdata;
    end
  end

  // Direct status read, whole word, answered next cycle
  always_comb begin
    ps_rdata_next = o_ps_rdata;
    ps_bad_next   = o_ps_bad;
    if (i_ps_en) begin
      ps_bad_next = !ps_ok;
      if (!i_ps_write) begin
        ps_rdata_next = ps_ok ? regs[ps_addr] : 32'h0;
      end
    end
  end

  // Message parser, executor and reply sequencer
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    wr_op_next = wr_op_reg;
    fail_next  = fail_reg;
    ret_next   = ret_reg;
    num_next   = num_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    f_ready    = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        f_ready = 1'b1;
        if (f_valid && f_ctrl
            && (f_data == crmp_pkg::TOK_WRITE || f_data == crmp_pkg::TOK_READ)) begin
          wr_op_next = (f_data == crmp_pkg::TOK_WRITE);
          fail_next  = !dest_ok;
          cnt_next   = '0;
          st_next    = ST_RETID;
        end
      end
      ST_RETID, ST_REGNUM, ST_WDATA: begin
        f_ready = 1'b1;
        if (f_valid && f_ctrl) begin
          fail_next = 1'b1;   // token where a field byte belongs
          st_next   = (f_data == crmp_pkg::TOK_END) ? ST_EXEC : ST_DRAIN;
        end else if (f_valid) begin
          cnt_next = cnt_reg + 1'b1;
          if (st_reg == ST_RETID) begin
            ret_next = {ret_reg[15:0], f_data};
            if (cnt_reg == 2'(crmp_pkg::RET_ID_BYTES - 1)) begin
              cnt_next = '0;
              st_next  = ST_REGNUM;
            end
          end else if (st_reg == ST_REGNUM) begin
            num_next = {num_reg[7:0], f_data};
            if (cnt_reg == 2'(crmp_pkg::REG_NUM_BYTES - 1)) begin
              cnt_next = '0;
              st_next  = wr_op_reg ? ST_WDATA : ST_ENDTOK;   // Reads carry no data
            end
          end else begin
            wdata_next = {wdata_reg[23:0], f_data};
            if (cnt_reg == 2'(crmp_pkg::DATA_BYTES - 1)) begin
              st_next = ST_ENDTOK;
            end
          end
        end
      end
      ST_ENDTOK: begin
        f_ready = 1'b1;
        if (f_valid) begin
          if (f_ctrl && f_data == crmp_pkg::TOK_END) begin
            st_next = ST_EXEC;
          end else begin
            fail_next = 1'b1;   // message too long or wrong close
            st_next   = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        f_ready = 1'b1;
        if (f_valid && f_ctrl && f_data == crmp_pkg::TOK_END) begin
          st_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Write lands or read is captured before any reply byte
        if (fail_reg || !msg_ok) begin
          fail_next = 1'b1;
          idx_next  = '0;
          st_next   = ST_REPLY;
        end else if (!(wr_op_reg && i_ps_en && i_ps_write)) begin
          rdata_next = regs[msg_addr];
          idx_next   = '0;
          st_next    = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (link.rsp_ready) begin
          idx_next = idx_reg + 1'b1;
          if (last) begin
            st_next = ST_IDLE;   // Next request only after this reply
          end
        end
      end
    endcase
  end

  // Reply bytes: 3 (value) 1 on success, 4 1 on failure
  always_comb begin
    link.rsp_valid = (st_reg == ST_REPLY);
    link.rsp_ctrl  = 1'b1;
    link.rsp_data  = crmp_pkg::TOK_END;
    last           = 1'b0;
    if (idx_reg == 3'h0) begin
      link.rsp_data = fail_reg ? crmp_pkg::TOK_NACK : crmp_pkg::TOK_ACK;
    end else if (!fail_reg && !wr_op_reg && idx_reg <= 3'(crmp_pkg::DATA_BYTES)) begin
      link.rsp_ctrl = 1'b0;
      link.rsp_data = rdata_reg[8*(crmp_pkg::DATA_BYTES - 32'(idx_reg)) +: 8];   // MSB first
    end else begin
      last = 1'b1;
    end
  end

  assign link.rsp_dest = ret_reg;
  assign o_busy        = (st_reg != ST_IDLE);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= '0;
      idx_reg    <= '0;
      wr_op_reg  <= 1'b0;
      fail_reg   <= 1'b0;
      ret_reg    <= '0;
      num_reg    <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      o_ps_rdata <= '0;
      o_ps_bad   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      idx_reg    <= idx_next;
      wr_op_reg  <= wr_op_next;
      fail_reg   <= fail_next;
      ret_reg    <= ret_next;
      num_reg    <= num_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      o_ps_rdata <= ps_rdata_next;
      o_ps_bad   <= ps_bad_next;
    end
  end
endmodule // crmp_agent

// ==== rtl/crmp_requester.sv ====
/*
  Requesting end: turns one user command into a framed read or write message,
  sets the channel-end destination, collects the reply. Also forms the status
  resource identifier for a status register number.
  Assumes one clock, synchronous active-high reset, link joined by the bench.
*/
`timescale 1ns/10ps
module crmp_requester (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  crmp_link_if.req         link,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire logic        i_cmd_write,
  input  wire logic        i_cmd_node,    // Node registers instead of tile registers
  input  wire logic [15:0] i_cmd_target,  // Tile or node identifier
  input  wire logic [23:0] i_cmd_ret_id,
  input  wire logic [15:0] i_cmd_reg,
  input  wire logic [31:0] i_cmd_wdata,
  output logic             o_done,        // One-cycle pulse when the reply closes
  output logic             o_ok,
  output logic      [31:0] o_rdata,
  input  wire logic [7:0]  i_ps_num,
  output logic      [31:0] o_ps_resid
);
  typedef enum {RQ_IDLE, RQ_SEND, RQ_WAIT} crmp_rq_state_e;

  crmp_rq_state_e st_reg, st_next;
  logic [3:0]  idx_reg, idx_next;
  logic        wr_reg, wr_next, ok_next, done_next;
  logic [31:0] dest_reg, dest_next, rdata_next;
  logic [23:0] ret_reg, ret_next;
  logic [15:0] num_reg, num_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  last_idx;

  // Message layout, byte by byte
  assign last_idx = wr_reg ? 4'ha : 4'h6;
  always_comb begin
    link.req_ctrl = 1'b0;
    link.req_data = 8'h00;
    unique case (idx_reg)
      4'h0: begin
        link.req_ctrl = 1'b1;
        link.req_data = wr_reg ? crmp_pkg::TOK_WRITE : crmp_pkg::TOK_READ;
      end
      4'h1: link.req_data = ret_reg[23:16];
      4'h2: link.req_data = ret_reg[15:8];
      4'h3: link.req_data = ret_reg[7:0];
      4'h4: link.req_data = num_reg[15:8];
      4'h5: link.req_data = num_reg[7:0];
      default: begin
        if (idx_reg == last_idx) begin
          link.req_ctrl = 1'b1;
          link.req_data = crmp_pkg::TOK_END;
        end else begin
          link.req_data = wdata_reg[8*(9 - 32'(idx_reg)) +: 8];
        end
      end
    endcase
  end

  assign link.req_valid = (st_reg == RQ_SEND);
  assign link.req_dest  = dest_reg;
  assign link.rsp_ready = (st_reg == RQ_WAIT);
  assign o_cmd_ready    = (st_reg == RQ_IDLE);

  // Command capture, sending and reply collection
  always_comb begin
    st_next    = st_reg;
    idx_next   = idx_reg;
    wr_next    = wr_reg;
    dest_next  = dest_reg;
    ret_next   = ret_reg;
    num_next   = num_reg;
    wdata_next = wdata_reg;
    ok_next    = o_ok;
    rdata_next = o_rdata;
    done_next  = 1'b0;
    unique case (st_reg)
      RQ_IDLE: begin
        if (i_cmd_valid) begin
          wr_next    = i_cmd_write;
          // Identifier above, fixed suffix in the low half
          dest_next  = {i_cmd_target, i_cmd_node ? crmp_pkg::NODE_SUFFIX : crmp_pkg::TILE_SUFFIX};
          ret_next   = i_cmd_ret_id;
          num_next   = i_cmd_reg;
          wdata_next = i_cmd_wdata;
          idx_next   = '0;
          st_next    = RQ_SEND;
        end
      end
      RQ_SEND: begin
        if (link.req_ready) begin
          idx_next = idx_reg + 1'b1;
          if (idx_reg == last_idx) begin
            ok_next = 1'b0;
            st_next = RQ_WAIT;
          end
        end
      end
      RQ_WAIT: begin
        if (link.rsp_valid) begin
          if (link.rsp_ctrl && link.rsp_data == crmp_pkg::TOK_END) begin
            done_next = 1'b1;
            st_next   = RQ_IDLE;
          end else if (link.rsp_ctrl) begin
            ok_next = (link.rsp_data == crmp_pkg::TOK_ACK);
          end else begin
            rdata_next = {o_rdata[23:0], link.rsp_data};
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg     <= RQ_IDLE;
      idx_reg    <= '0;
      wr_reg     <= 1'b0;
      dest_reg   <= '0;
      ret_reg    <= '0;
      num_reg    <= '0;
      wdata_reg  <= '0;
      o_ok       <= 1'b0;
      o_rdata    <= '0;
      o_done     <= 1'b0;
      o_ps_resid <= '0;
    end else begin
      st_reg     <= st_next;
      idx_reg    <= idx_next;
      wr_reg     <= wr_next;
      dest_reg   <= dest_next;
      ret_reg    <= ret_next;
      num_reg    <= num_next;
      wdata_reg  <= wdata_next;
      o_ok       <= ok_next;
      o_rdata    <= rdata_next;
      o_done     <= done_next;
      // Status resource identifier
      o_ps_resid <= ({24'h0, i_ps_num} << crmp_pkg::PS_NUM_SHIFT) | {24'h0, crmp_pkg::PS_RES_TYPE};
    end
  end
endmodule // crmp_requester

// ==== verif/crmp_link_monitor.sv ====
/*
  Checker for the token link that joins the requester and the agent.
  Assumes it sees the plain signals of that interface and one clock.
*/
`timescale 1ns/10ps
module crmp_link_monitor (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        req_valid,
  input  wire logic        req_ready,
  input  wire logic        req_ctrl,
  input  wire logic [7:0]  req_data,
  input  wire logic [31:0] req_dest,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ready,
  input  wire logic        rsp_ctrl,
  input  wire logic [7:0]  rsp_data,
  input  wire logic [23:0] rsp_dest
);
  logic       req_go, rsp_go, req_end;
  logic       mid_reg, mid_next, rmid_reg, rmid_next;
  logic       out_reg, out_next, wr_reg, wr_next;
  logic [3:0] cnt_reg, cnt_next;

  default clocking mon_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  //////////////////////////////////////////////////////////////////////////////
  // Byte transfers and the closing token
  assign req_go  = req_valid && req_ready;
  assign rsp_go  = rsp_valid && rsp_ready;
  assign req_end = req_ctrl && req_data == crmp_pkg::TOK_END;

  // Position in the message, in the reply, and data byte count
  always_comb begin
    mid_next  = mid_reg;
    rmid_next = rmid_reg;
    out_next  = out_reg;
    wr_next   = wr_reg;
    cnt_next  = cnt_reg;
    if (req_go && req_ctrl && !mid_reg) begin
      mid_next = 1'b1;
      wr_next  = req_data == crmp_pkg::TOK_WRITE;
      cnt_next = 4'h0;
    end
    if (req_go && !req_ctrl) begin
      cnt_next = cnt_reg + 4'h1;
    end
    if (req_go && req_end) begin
      mid_next = 1'b0;
      out_next = 1'b1;
    end
    if (rsp_go) begin
      rmid_next = !(rsp_ctrl && rsp_data == crmp_pkg::TOK_END);
      out_next  = out_next && rmid_next;   // Closing reply token ends the exchange
    end
    if (i_reset) begin
      mid_next  = 1'b0;
      rmid_next = 1'b0;
      out_next  = 1'b0;
      wr_next   = 1'b0;
      cnt_next  = 4'h0;
    end
  end

  // Tracker registers
  always_ff @(posedge i_core_clk) begin
    mid_reg  <= mid_next;
    rmid_reg <= rmid_next;
    out_reg  <= out_next;
    wr_reg   <= wr_next;
    cnt_reg  <= cnt_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link properties
  req_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_data) && $stable(req_ctrl)) else $error("request byte dropped");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_ctrl)) else $error("reply byte dropped");
  rsp_open_a: assert property (rsp_valid && !rmid_reg |-> rsp_ctrl &&
    (rsp_data == crmp_pkg::TOK_ACK || rsp_data == crmp_pkg::TOK_NACK)) else $error("bad reply");
  nack_close_a: assert property (rsp_go && rsp_ctrl && rsp_data == crmp_pkg::TOK_NACK
    |-> ##[1:4] (rsp_valid && rsp_ctrl && rsp_ready && rsp_data == crmp_pkg::TOK_END))
    else $error("failure reply not closed");
  rsp_gap_a: assert property (rsp_valid |-> !mid_reg)
    else $error("reply during a message");
  one_out_a: assert property (req_valid && req_ctrl && !mid_reg |-> !out_reg &&
    (req_data == crmp_pkg::TOK_WRITE || req_data == crmp_pkg::TOK_READ))
    else $error("second message or bad opening");
  dest_sfx_a: assert property (req_valid |-> req_dest[15:0] == crmp_pkg::TILE_SUFFIX ||
    req_dest[15:0] == crmp_pkg::NODE_SUFFIX) else $error("bad destination suffix");
  msg_len_a: assert property (req_go && req_end |-> cnt_reg == (wr_reg ? 4'h9 : 4'h5))
    else $error("message length wrong");
  reply_time_a: assert property (req_go && req_end |-> ##1 !rsp_valid
    ##[1:40] rsp_valid) else $error("reply timing wrong");

  // Main scenarios reached
  cover property (req_go && req_end && wr_reg);
  cover property (req_go && req_end && !wr_reg);
  cover property (rsp_go && rsp_ctrl && rsp_data == crmp_pkg::TOK_NACK);
endmodule // crmp_link_monitor

// ==== verif/config_register_message_port_tb.sv ====
/*
  Testbench: requester and agent joined by one link, a second agent driven
  directly on a second link for malformed framing and a full request FIFO.
  Assumes the design files and the package are compiled first.
*/
`timescale 1ns/10ps
module config_register_message_port_tb;
  logic        i_core_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        cmd_valid, cmd_ready, cmd_write, cmd_node, done, ok, ps_en, ps_write;
  logic        ps_bad, busy;
  logic [15:0] cmd_reg;
  logic [31:0] cmd_wdata, rdata, ps_resid, ps_wdata, ps_rdata, ps_res_out;
  logic [7:0]  ps_num;
  logic [8:0]  q[$], r[$];
  int          fails = 0;
  int          check_count = 0;

  crmp_link_if link_a ();
  crmp_link_if link_b ();

  //////////////////////////////////////////////////////////////////////////////
  // Clock and design ends
  always #4 i_core_clk = ~i_core_clk;

  crmp_requester i_crmp_requester (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .link(link_a.req), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_write(cmd_write), .i_cmd_node(cmd_node), .i_cmd_target(16'h0001),
    .i_cmd_ret_id({8'ha5, cmd_reg}), .i_cmd_reg(cmd_reg), .i_cmd_wdata(cmd_wdata),
    .o_done(done), .o_ok(ok), .o_rdata(rdata), .i_ps_num(ps_num), .o_ps_resid(ps_res_out));
  crmp_agent i_crmp_agent (.i_core_clk(i_core_clk), .i_reset(i_reset), .link(link_a.dev),
    .i_ps_en(ps_en), .i_ps_write(ps_write), .i_ps_resid(ps_resid), .i_ps_wdata(ps_wdata),
    .o_ps_rdata(ps_rdata), .o_ps_bad(ps_bad), .o_busy(busy));
  crmp_agent i_crmp_agent_b (.i_core_clk(i_core_clk), .i_reset(i_reset), .link(link_b.dev),
    .i_ps_en(1'b0), .i_ps_write(1'b0), .i_ps_resid(32'h0), .i_ps_wdata(32'h0),
    .o_ps_rdata(), .o_ps_bad(), .o_busy());
  crmp_link_monitor i_crmp_link_monitor (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .req_valid(link_a.req_valid), .req_ready(link_a.req_ready), .req_ctrl(link_a.req_ctrl),
    .req_data(link_a.req_data), .req_dest(link_a.req_dest), .rsp_valid(link_a.rsp_valid),
    .rsp_ready(link_a.rsp_ready), .rsp_ctrl(link_a.rsp_ctrl), .rsp_data(link_a.rsp_data),
    .rsp_dest(link_a.rsp_dest));

  //////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and hang handling
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    fails++;
    $display("Error at %0t: wait ran out", $time);
    complete_run();
  endtask

  // One command through the requester; return id follows the register number
  task automatic cmd(input logic w, input logic nd, input logic [15:0] rg,
                     input logic [31:0] wd, input logic exp_ok, input logic [31:0] exp_rd);
    int   n;
    @(posedge i_core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_node  <= nd;
    cmd_reg   <= rg;
    cmd_wdata <= wd;
    @(posedge i_core_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 100 && done !== 1'b1; n++) begin
      @(posedge i_core_clk);
      #1;
      if (link_a.req_valid === 1'b1)
        check(link_a.req_dest, {16'h0001, (nd ? crmp_pkg::NODE_SUFFIX
                                               : crmp_pkg::TILE_SUFFIX)});
    end
    if (done !== 1'b1) hang();
    check(ok, exp_ok);
    check(link_a.rsp_dest, {8'ha5, rg});
    if (!w && exp_ok) check(rdata, exp_rd);
  endtask

  // One status get or set, answer sampled a cycle later
  task automatic ps(input logic w, input logic [31:0] id, input logic [31:0] wd,
                    input logic [31:0] exp_rd, input logic exp_bad);
    @(posedge i_core_clk);
    ps_en    <= 1'b1;
    ps_write <= w;
    ps_resid <= id;
    ps_wdata <= wd;
    @(posedge i_core_clk);
    ps_en <= 1'b0;
    #1;
    check(ps_bad, exp_bad);
    if (!w) check(ps_rdata, exp_rd);
  endtask

  // Second link: hold a byte until taken; called on a clock edge
  task automatic put_b(input logic [8:0] b);
    int n;
    link_b.req_valid <= 1'b1;
    link_b.req_ctrl  <= b[8];
    link_b.req_data  <= b[7:0];
    for (n = 0; n < 20; n++) begin
      @(posedge i_core_clk);
      if (link_b.req_ready === 1'b1) break;
    end
    if (n == 20) hang();
  endtask

  // Second link: take the next reply byte and compare it
  task automatic get_b(input logic [8:0] b);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge i_core_clk);
      if (link_b.rsp_valid === 1'b1) break;
    end
    if (n == 40) hang();
    check({link_b.rsp_ctrl, link_b.rsp_data}, b);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {cmd_valid, cmd_write, cmd_node, ps_en, ps_write} = 5'h00;
    {cmd_reg, cmd_wdata, ps_resid, ps_wdata, ps_num} = 120'h0;
    {link_b.req_valid, link_b.req_ctrl, link_b.req_data, link_b.rsp_ready} = 11'h000;
    link_b.req_dest = 32'h0005_c20c;
    repeat (5) @(posedge i_core_clk);
    i_reset <= 1'b0;
    #1;
    check({cmd_ready, busy}, 32'h2);
    cmd(1, 0, 16'h0102, 32'h1234_5678, 1, 0);
    cmd(0, 0, 16'h0102, 0, 1, 32'h1234_5678);
    cmd(1, 1, 16'h0903, 32'h89ab_cdef, 1, 0);
    cmd(0, 1, 16'h0903, 0, 1, 32'h89ab_cdef);
    cmd(1, 0, 16'h0a00, 32'hffff_ffff, 0, 0);
    cmd(1, 1, 16'h0904, 32'hffff_ffff, 0, 0);
    cmd(1, 0, 16'h1000, 32'hffff_ffff, 0, 0);
    cmd(0, 0, 16'h0900, 0, 1, 32'h0);
    cmd(0, 1, 16'h0a00, 0, 0, 0);
    ps(1, 32'h0000_020c, 32'hcafe_0002, 0, 0);
    ps(0, 32'h0000_020c, 0, 32'hcafe_0002, 0);
    ps(0, 32'h0000_020d, 0, 0, 1);
    ps(1, 32'h0000_040c, 32'h1, 0, 1);
    ps(0, 32'h0001_000c, 0, 0, 1);
    cmd(0, 0, 16'h0002, 0, 1, 32'hcafe_0002);
    cmd(1, 1, 16'h0001, 32'h5555_aaaa, 1, 0);
    ps(0, 32'h0000_010c, 0, 32'h5555_aaaa, 0);
    @(posedge i_core_clk);
    ps_num <= 8'h02;
    repeat (2) @(posedge i_core_clk);
    #1;
    check(ps_res_out, 32'h0000_020c);
    // Token where the register number belongs, reply held off
    @(posedge i_core_clk);
    q = '{9'h1c1, 9'h012, 9'h034, 9'h056, 9'h101, 9'h1c0, 9'h012, 9'h034, 9'h056};
    foreach (q[i]) put_b(q[i]);
    link_b.req_data <= 8'h00;
    repeat (3) @(posedge i_core_clk);
    #1;
    check(link_b.req_ready, 1'b0);
    @(posedge i_core_clk);
    link_b.rsp_ready <= 1'b1;
    fork
      put_b(9'h000);
      begin
        get_b(9'h104);
        get_b(9'h101);
      end
    join
    q = '{9'h003, 9'h0de, 9'h0ad, 9'h0be, 9'h0ef, 9'h101, 9'h1c1, 9'h012, 9'h034, 9'h056,
          9'h000, 9'h003, 9'h101};
    r = '{9'h103, 9'h101, 9'h103, 9'h0de, 9'h0ad, 9'h0be, 9'h0ef, 9'h101};
    fork
      begin
        foreach (q[i]) put_b(q[i]);
        link_b.req_valid <= 1'b0;
      end
      foreach (r[i]) get_b(r[i]);
    join
    complete_run();
  end
endmodule // config_register_message_port_tb
